/* hw/epv_regs.svh */
// register offsets, field positions, reset values and vector codes of the
// exception prioritisation block; definitions only
`ifndef EPV_REGS_SVH
`define EPV_REGS_SVH

// register offsets on the byte-wide register port
`define EPV_ADDR_W 8
`define EPV_OFS_CONTROL 8'h00
`define EPV_OFS_PRIORITY 8'h01
`define EPV_OFS_MASKS 8'h02
`define EPV_OFS_WAKE_G 8'h03
`define EPV_OFS_WAKE_H 8'h04
`define EPV_OFS_LOCAL 8'h05
`define EPV_OFS_STATUS 8'h06

// field positions
`define EPV_BIT_EDGE_ONLY 7
`define EPV_BIT_EXT_CONNECT 6
`define EPV_BIT_X_MASK 6
`define EPV_BIT_I_MASK 4
`define EPV_BIT_LOCK_EN 0
`define EPV_BIT_LIMP_EN 1
`define EPV_BIT_SERIAL_EN 2
`define EPV_BIT_MODULUS_EN 3

// reset values
`define EPV_RST_PRIORITY 8'hF2
`define EPV_RST_CONNECT 1'b1
`define EPV_RST_EDGE_ONLY 1'b0

// fixed vectors of the non-maskable sources
`define EPV_VEC_RESET 16'hFFFE
`define EPV_VEC_CLKMON 16'hFFFC
`define EPV_VEC_WDOG 16'hFFFA
`define EPV_VEC_TRAP 16'hFFF8
`define EPV_VEC_SWI 16'hFFF6
`define EPV_VEC_NMI 16'hFFF4
`define EPV_VEC_PAGE 8'hFF

// maskable vector low bytes
`define EPV_LO_TOP 8'hF2
`define EPV_LO_BOTTOM 8'hC2
`define EPV_LO_SERIAL 8'hD8
`define EPV_LO_WAKE 8'hCE
`define EPV_LO_MODULUS 8'hCC
`define EPV_LO_CLKGEN 8'hC2

`endif

/* hw/epv_pkg.sv */
// types shared by the exception prioritisation block
// assumes epv_regs.svh carries all numeric constants
package epv_pkg;
  typedef logic [15:0] epv_vector_t;
  typedef logic [7:0] epv_byte_t;
endpackage

/* hw/epv_top.sv */
// exception prioritisation and vector generation for the cpu core
// assumes one system clock; request pins are asynchronous, core and
// peripheral flags come from logic on the same clock
`timescale 1ns/1ps
`include "epv_regs.svh"

module epv_top #(
  parameter int NUM_MASKABLE = 25
) (
  input wire logic I_MCLK,
  input wire logic I_RST_N,
  // register port
  input wire logic [7:0] I_ADDR,
  input wire logic [7:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [7:0] O_RDATA,
  // reset and non-maskable requests from the core and its monitors
  input wire logic I_CLKMON_FAIL,
  input wire logic I_WDOG_FAIL,
  input wire logic I_OPCODE_TRAP,
  input wire logic I_SWI,
  // asynchronous request pins, active low
  input wire logic I_NMI_REQ_N,
  input wire logic I_EXT_REQ_N,
  // peripheral flags, one per maskable vector; serial, modulus, wake, lock and limp enables applied here, the others upstream
  input wire logic [NUM_MASKABLE-1:0] I_PERIPH_FLAG,
  input wire logic [6:0] I_WAKE_G_FLAG,
  input wire logic [7:0] I_WAKE_H_FLAG,
  input wire logic I_LOCK_FLAG,
  input wire logic I_LIMP_FLAG,
  // core takes the vector in this cycle
  input wire logic I_VECTOR_FETCH,
  output logic [15:0] O_VECTOR,
  output logic O_PENDING,
  output logic O_I_MASK,
  output logic O_X_MASK
);

  localparam int IDX_EXT = 0;
  localparam int IDX_SERIAL = (`EPV_LO_TOP - `EPV_LO_SERIAL) / 2;
  localparam int IDX_WAKE = (`EPV_LO_TOP - `EPV_LO_WAKE) / 2;
  localparam int IDX_MODULUS = (`EPV_LO_TOP - `EPV_LO_MODULUS) / 2;
  localparam int IDX_CLKGEN = (`EPV_LO_TOP - `EPV_LO_CLKGEN) / 2;

  // the vector table spans F2 down to C2; other sizes cannot map
  if (NUM_MASKABLE != (`EPV_LO_TOP - `EPV_LO_BOTTOM) / 2 + 1) begin : g_bad_size
    $error("NUM_MASKABLE must cover the maskable vector range");
  end

  // control state
  logic edge_only_select;
  logic external_request_connect;
  epv_pkg::epv_byte_t top_priority_select;
  logic i_mask;
  logic x_mask;
  logic [6:0] port_g_wake_enables;
  logic [7:0] port_h_wake_enables;
  logic lock_event_enable;
  logic limp_home_enable;
  logic serial_transfer_irq_enable;
  logic modulus_underflow_enable;
  logic reset_pending;

  // pin synchronisers and edge latch
  logic nmi_s1;
  logic nmi_s2;
  logic ext_s1;
  logic ext_s2;
  logic ext_prev;
  logic edge_latch;

  logic wr_control;
  logic wr_priority;
  logic wr_masks;
  logic wr_wake_g;
  logic wr_wake_h;
  logic wr_local;

  assign wr_control = I_WR && (I_ADDR == `EPV_OFS_CONTROL);
  assign wr_priority = I_WR && (I_ADDR == `EPV_OFS_PRIORITY);
  assign wr_masks = I_WR && (I_ADDR == `EPV_OFS_MASKS);
  assign wr_wake_g = I_WR && (I_ADDR == `EPV_OFS_WAKE_G);
  assign wr_wake_h = I_WR && (I_ADDR == `EPV_OFS_WAKE_H);
  assign wr_local = I_WR && (I_ADDR == `EPV_OFS_LOCAL);

  // two-flop synchronisers for both request pins
  always_ff @(posedge I_MCLK) begin
    if (!I_RST_N) begin
      nmi_s1 <= 1'b1;
      nmi_s2 <= 1'b1;
      ext_s1 <= 1'b1;
      ext_s2 <= 1'b1;
      ext_prev <= 1'b1;
    end else begin
      nmi_s1 <= I_NMI_REQ_N;
      nmi_s2 <= nmi_s1;
      ext_s1 <= I_EXT_REQ_N;
      ext_s2 <= ext_s1;
      ext_prev <= ext_s2;
    end
  end

  // external pin configuration
  always_ff @(posedge I_MCLK) begin
    if (!I_RST_N) begin
      edge_only_select <= `EPV_RST_EDGE_ONLY;
      external_request_connect <= `EPV_RST_CONNECT;
    end else if (wr_control) begin
      edge_only_select <= I_WDATA[`EPV_BIT_EDGE_ONLY];
      external_request_connect <= I_WDATA[`EPV_BIT_EXT_CONNECT];
    end
  end

  // promotion select, only changeable while maskable requests are inhibited
  always_ff @(posedge I_MCLK) begin
    if (!I_RST_N) begin
      top_priority_select <= `EPV_RST_PRIORITY;
    end else if (wr_priority && i_mask) begin
      top_priority_select <= I_WDATA;
    end
  end

  // local enables of the gated sources
  always_ff @(posedge I_MCLK) begin
    if (!I_RST_N) begin
      port_g_wake_enables <= 7'h00;
      port_h_wake_enables <= 8'h00;
      lock_event_enable <= 1'b0;
      limp_home_enable <= 1'b0;
      serial_transfer_irq_enable <= 1'b0;
      modulus_underflow_enable <= 1'b0;
    end else begin
      if (wr_wake_g) begin
        port_g_wake_enables <= I_WDATA[6:0];
      end
      if (wr_wake_h) begin
        port_h_wake_enables <= I_WDATA;
      end
      if (wr_local) begin
        lock_event_enable <= I_WDATA[`EPV_BIT_LOCK_EN];
        limp_home_enable <= I_WDATA[`EPV_BIT_LIMP_EN];
        serial_transfer_irq_enable <= I_WDATA[`EPV_BIT_SERIAL_EN];
        modulus_underflow_enable <= I_WDATA[`EPV_BIT_MODULUS_EN];
      end
    end
  end

  // falling edge latch: set wins over the service clear
  logic ext_fall;
  logic ext_serviced;
  assign ext_fall = ext_prev && !ext_s2 && external_request_connect;
  assign ext_serviced = I_VECTOR_FETCH && O_PENDING
                        && (O_VECTOR == {`EPV_VEC_PAGE, `EPV_LO_TOP});

  always_ff @(posedge I_MCLK) begin
    if (!I_RST_N) begin
      edge_latch <= 1'b0;
    end else if (!edge_only_select) begin
      edge_latch <= 1'b0;
    end else if (ext_fall) begin
      edge_latch <= 1'b1;
    end else if (ext_serviced) begin
      edge_latch <= 1'b0;
    end
  end

  // maskable request vector with local gating
  logic [NUM_MASKABLE-1:0] mreq;
  always_comb begin
    mreq = I_PERIPH_FLAG;
    // level mode follows the pin, edge mode the latch
    mreq[IDX_EXT] = external_request_connect
                    && (edge_only_select ? edge_latch : !ext_s2);
    mreq[IDX_SERIAL] = I_PERIPH_FLAG[IDX_SERIAL] && serial_transfer_irq_enable;
    mreq[IDX_WAKE] = |(I_WAKE_G_FLAG & port_g_wake_enables)
                     || |(I_WAKE_H_FLAG & port_h_wake_enables);
    mreq[IDX_MODULUS] = I_PERIPH_FLAG[IDX_MODULUS] && modulus_underflow_enable;
    mreq[IDX_CLKGEN] = (I_LOCK_FLAG && lock_event_enable)
                       || (I_LIMP_FLAG && limp_home_enable);
  end

  // promoted index from the stored byte; invalid codes fall back to the pin
  logic promo_valid;
  logic [7:0] promo_diff;
  logic [4:0] promo_idx;
  assign promo_valid = !top_priority_select[0]
                       && (top_priority_select <= `EPV_LO_TOP)
                       && (top_priority_select >= `EPV_LO_BOTTOM);
  assign promo_diff = `EPV_LO_TOP - top_priority_select;
  assign promo_idx = promo_valid ? promo_diff[5:1] : 5'h00;

  // maskable winner: promoted source first, then descending vector order
  logic mwin_any;
  logic [4:0] mwin_idx;
  always_comb begin
    mwin_any = 1'b0;
    mwin_idx = 5'h00;
    for (int i = NUM_MASKABLE - 1; i >= 0; i--) begin
      if (mreq[i]) begin
        mwin_any = 1'b1;
        mwin_idx = 5'(i);
      end
    end
    if (mreq[promo_idx]) begin
      mwin_idx = promo_idx;
    end
  end

  // vector of the maskable winner, independent of promotion
  logic [7:0] mwin_lo;
  assign mwin_lo = `EPV_LO_TOP - {2'h0, mwin_idx, 1'b0};

  // overall ranking of the exception sources
  logic nmi_active;
  logic mask_active;
  epv_pkg::epv_vector_t next_vector;
  logic next_pending;
  assign nmi_active = !nmi_s2 && !x_mask;
  assign mask_active = mwin_any && !i_mask;

  always_comb begin
    next_pending = 1'b1;
    if (reset_pending) begin
      next_vector = `EPV_VEC_RESET;
    end else if (I_CLKMON_FAIL) begin
      next_vector = `EPV_VEC_CLKMON;
    end else if (I_WDOG_FAIL) begin
      next_vector = `EPV_VEC_WDOG;
    end else if (I_OPCODE_TRAP) begin
      next_vector = `EPV_VEC_TRAP;
    end else if (I_SWI) begin
      next_vector = `EPV_VEC_SWI;
    end else if (nmi_active) begin
      next_vector = `EPV_VEC_NMI;
    end else if (mask_active) begin
      next_vector = {`EPV_VEC_PAGE, mwin_lo};
    end else begin
      // request withdrawn before service: core lands on the trap
      next_pending = 1'b0;
      next_vector = `EPV_VEC_TRAP;
    end
  end

  // registered vector and pending flag for the core
  always_ff @(posedge I_MCLK) begin
    if (!I_RST_N) begin
      O_VECTOR <= `EPV_VEC_RESET;
      O_PENDING <= 1'b1;
    end else begin
      O_VECTOR <= next_vector;
      O_PENDING <= next_pending;
    end
  end

  // reset vector stays first until the core has fetched it
  always_ff @(posedge I_MCLK) begin
    if (!I_RST_N) begin
      reset_pending <= 1'b1;
    end else if (I_VECTOR_FETCH && (O_VECTOR == `EPV_VEC_RESET)) begin
      reset_pending <= 1'b0;
    end
  end

  // global masks: set on reset, I by maskable and pin NMI service entry, X by pin NMI entry only; written by software
  logic serv_mask;
  logic serv_nmi;
  assign serv_mask = I_VECTOR_FETCH && O_PENDING && (O_VECTOR[7:0] <= `EPV_LO_TOP);
  assign serv_nmi = I_VECTOR_FETCH && O_PENDING && (O_VECTOR == `EPV_VEC_NMI);

  always_ff @(posedge I_MCLK) begin
    if (!I_RST_N) begin
      i_mask <= 1'b1;
      x_mask <= 1'b1;
    end else if (serv_mask || serv_nmi) begin
      i_mask <= 1'b1;
      x_mask <= serv_nmi ? 1'b1 : x_mask;
    end else if (wr_masks) begin
      i_mask <= I_WDATA[`EPV_BIT_I_MASK];
      x_mask <= I_WDATA[`EPV_BIT_X_MASK];
    end
  end

  always_ff @(posedge I_MCLK) begin
    if (!I_RST_N) begin
      O_I_MASK <= 1'b1;
      O_X_MASK <= 1'b1;
    end else begin
      O_I_MASK <= i_mask;
      O_X_MASK <= x_mask;
    end
  end

  // read data one cycle after the strobe, zero otherwise
  epv_pkg::epv_byte_t next_rdata;
  always_comb begin
    next_rdata = 8'h00;
    if (I_RD) begin
      case (I_ADDR)
        `EPV_OFS_CONTROL: begin
          next_rdata[`EPV_BIT_EDGE_ONLY] = edge_only_select;
          next_rdata[`EPV_BIT_EXT_CONNECT] = external_request_connect;
        end
        `EPV_OFS_PRIORITY: next_rdata = top_priority_select;
        `EPV_OFS_MASKS: begin
          next_rdata[`EPV_BIT_X_MASK] = x_mask;
          next_rdata[`EPV_BIT_I_MASK] = i_mask;
        end
        `EPV_OFS_WAKE_G: next_rdata = {1'b0, port_g_wake_enables};
        `EPV_OFS_WAKE_H: next_rdata = port_h_wake_enables;
        `EPV_OFS_LOCAL: begin
          next_rdata[`EPV_BIT_LOCK_EN] = lock_event_enable;
          next_rdata[`EPV_BIT_LIMP_EN] = limp_home_enable;
          next_rdata[`EPV_BIT_SERIAL_EN] = serial_transfer_irq_enable;
          next_rdata[`EPV_BIT_MODULUS_EN] = modulus_underflow_enable;
        end
        `EPV_OFS_STATUS: next_rdata = {5'h00, !ext_s2, edge_latch, O_PENDING};
        default: next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge I_MCLK) begin
    if (!I_RST_N) begin
      O_RDATA <= 8'h00;
    end else begin
      O_RDATA <= next_rdata;
    end
  end

endmodule

/* bench/epv_top_props.sv */
// assertions on the ports of the exception prioritisation block
// assumes one clock and a synchronous active-low reset
`timescale 1ns/1ps
module epv_top_props (
  input wire logic I_MCLK,
  input wire logic I_RST_N,
  input wire logic [7:0] I_ADDR,
  input wire logic [7:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_CLKMON_FAIL,
  input wire logic I_WDOG_FAIL,
  input wire logic I_OPCODE_TRAP,
  input wire logic I_SWI,
  input wire logic I_VECTOR_FETCH,
  input wire logic [15:0] O_VECTOR,
  input wire logic O_PENDING,
  input wire logic O_I_MASK,
  input wire logic O_X_MASK
);
  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (!I_RST_N);
  logic calm;
  // no fetch now and the reset vector already taken
  assign calm = !I_VECTOR_FETCH && (O_VECTOR != 16'hFFFE);
  property p_reset_state;
    $rose(I_RST_N) |-> O_VECTOR == 16'hFFFE && O_PENDING && O_I_MASK && O_X_MASK;
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("reset state wrong");
  property p_clkmon_top;
    I_CLKMON_FAIL && calm |=> O_VECTOR == 16'hFFFC;
  endproperty
  a_clkmon_top: assert property (p_clkmon_top) else $error("clock monitor not first");
  property p_wdog_next;
    I_WDOG_FAIL && !I_CLKMON_FAIL && calm |=> O_VECTOR == 16'hFFFA;
  endproperty
  a_wdog_next: assert property (p_wdog_next) else $error("watchdog order wrong");
  property p_swi_next;
    I_SWI && !(I_CLKMON_FAIL || I_WDOG_FAIL || I_OPCODE_TRAP) && calm |=> O_VECTOR == 16'hFFF6;
  endproperty
  a_swi_next: assert property (p_swi_next) else $error("software vector wrong");
  property p_i_gate;
    O_I_MASK && $stable(O_I_MASK) && O_PENDING |-> O_VECTOR[7:0] >= 8'hF4;
  endproperty
  a_i_gate: assert property (p_i_gate) else $error("maskable taken while masked");
  property p_x_gate;
    O_X_MASK && $stable(O_X_MASK) && O_PENDING |-> O_VECTOR != 16'hFFF4;
  endproperty
  a_x_gate: assert property (p_x_gate) else $error("pin request taken while masked");
  property p_idle_trap;
    !O_PENDING |-> O_VECTOR == 16'hFFF8;
  endproperty
  a_idle_trap: assert property (p_idle_trap) else $error("idle vector wrong");
  property p_vec_range;
    O_VECTOR[15:8] == 8'hFF && !O_VECTOR[0] && O_VECTOR[7:0] >= 8'h80;
  endproperty
  a_vec_range: assert property (p_vec_range) else $error("vector out of range");
  property p_service_i;
    I_VECTOR_FETCH && O_PENDING && O_VECTOR[7:0] <= 8'hF4 |-> ##2 O_I_MASK;
  endproperty
  a_service_i: assert property (p_service_i) else $error("service left I clear");
  property p_nmi_x;
    I_VECTOR_FETCH && O_VECTOR == 16'hFFF4 |-> ##2 O_X_MASK;
  endproperty
  a_nmi_x: assert property (p_nmi_x) else $error("pin service left X clear");
  property p_mask_write;
    I_WR && I_ADDR == 8'h02 && !I_VECTOR_FETCH && !I_WDATA[4] |-> ##2 !O_I_MASK;
  endproperty
  a_mask_write: assert property (p_mask_write) else $error("I mask not written");
  c_nmi: cover property (I_VECTOR_FETCH && O_VECTOR == 16'hFFF4);
  c_promoted: cover property (I_VECTOR_FETCH && O_VECTOR == 16'hFFD8);
  c_ext: cover property (I_VECTOR_FETCH && O_VECTOR == 16'hFFF2);
endmodule

bind epv_top epv_top_props props_u (.I_MCLK(I_MCLK), .I_RST_N(I_RST_N), .I_ADDR(I_ADDR),
  .I_WDATA(I_WDATA), .I_WR(I_WR), .I_CLKMON_FAIL(I_CLKMON_FAIL), .I_WDOG_FAIL(I_WDOG_FAIL),
  .I_OPCODE_TRAP(I_OPCODE_TRAP), .I_SWI(I_SWI), .I_VECTOR_FETCH(I_VECTOR_FETCH),
  .O_VECTOR(O_VECTOR), .O_PENDING(O_PENDING), .O_I_MASK(O_I_MASK), .O_X_MASK(O_X_MASK));

/* bench/epv_core_model.sv */
// cpu core stand-in: vector fetch pulses and the external request pin
// assumes bench commands change right after a rising edge
`timescale 1ns/1ps
module epv_core_model (
  input wire logic i_clk,
  input wire logic i_take,
  input wire logic i_ext_set,
  input wire logic i_ext_drop,
  output logic o_fetch,
  output logic o_ext_req_n
);
  // one driver per output; start idle with the pin at its pull-up level
  logic fetch_pulse = 1'b0;
  logic req_pin_n = 1'b1;
  assign o_fetch = fetch_pulse;
  assign o_ext_req_n = req_pin_n;
  // one fetch pulse per command
  always @(posedge i_clk) fetch_pulse <= i_take;
  // pin held low until the next fetch pulse or drop command, pull-up when released
  always @(posedge i_clk) begin
    if (i_ext_set) req_pin_n <= 1'b0;
    else if (fetch_pulse || i_ext_drop) req_pin_n <= 1'b1;
  end
endmodule

/* bench/epv_top_tb_top.sv */
// self-checking bench for the exception prioritisation block
// assumes design, checker and core model are compiled first
`timescale 1ns/1ps
module epv_top_tb_top;
  logic I_MCLK = 1'b0;
  logic I_RST_N = 1'b0;
  logic [7:0] I_ADDR = 8'h00;
  logic [7:0] I_WDATA = 8'h00;
  logic I_WR = 1'b0;
  logic I_RD = 1'b0;
  logic I_CLKMON_FAIL = 1'b0;
  logic I_WDOG_FAIL = 1'b0;
  logic I_OPCODE_TRAP = 1'b0;
  logic I_SWI = 1'b0;
  logic I_NMI_REQ_N = 1'b1;
  logic [24:0] I_PERIPH_FLAG = 25'h0;
  logic [6:0] I_WAKE_G_FLAG = 7'h00;
  logic I_LOCK_FLAG = 1'b0;
  logic [7:0] I_WAKE_H_FLAG = 8'h00;
  logic I_LIMP_FLAG = 1'b0;
  logic take = 1'b0;
  logic ext_set = 1'b0;
  logic ext_drop = 1'b0;
  logic I_VECTOR_FETCH;
  logic I_EXT_REQ_N;
  logic [7:0] O_RDATA;
  logic [15:0] O_VECTOR;
  logic O_PENDING;
  logic O_I_MASK;
  logic O_X_MASK;
  int fail_count = 0;
  int checked = 0;
  // clock and device
  always #25 I_MCLK = ~I_MCLK;
  epv_top dut_u (.I_MCLK(I_MCLK), .I_RST_N(I_RST_N), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA),
    .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA), .I_CLKMON_FAIL(I_CLKMON_FAIL),
    .I_WDOG_FAIL(I_WDOG_FAIL), .I_OPCODE_TRAP(I_OPCODE_TRAP), .I_SWI(I_SWI),
    .I_NMI_REQ_N(I_NMI_REQ_N), .I_EXT_REQ_N(I_EXT_REQ_N), .I_PERIPH_FLAG(I_PERIPH_FLAG),
    .I_WAKE_G_FLAG(I_WAKE_G_FLAG), .I_WAKE_H_FLAG(I_WAKE_H_FLAG), .I_LOCK_FLAG(I_LOCK_FLAG),
    .I_LIMP_FLAG(I_LIMP_FLAG), .I_VECTOR_FETCH(I_VECTOR_FETCH), .O_VECTOR(O_VECTOR),
    .O_PENDING(O_PENDING), .O_I_MASK(O_I_MASK), .O_X_MASK(O_X_MASK));
  epv_core_model core_u (.i_clk(I_MCLK), .i_take(take), .i_ext_set(ext_set),
    .i_ext_drop(ext_drop), .o_fetch(I_VECTOR_FETCH), .o_ext_req_n(I_EXT_REQ_N));
  // compare and count
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // register port cycles
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    I_ADDR <= a;
    I_WDATA <= d;
    I_WR <= 1'b1;
    @(posedge I_MCLK);
    I_WR <= 1'b0;
    @(posedge I_MCLK);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] exp);
    I_ADDR <= a;
    I_RD <= 1'b1;
    @(posedge I_MCLK);
    I_RD <= 1'b0;
    @(posedge I_MCLK);
    chk("read data", {8'h00, O_RDATA & m}, {8'h00, exp});
  endtask
  // bounded wait for a vector, then judge it and the pending flag
  task automatic see(input logic [15:0] exp, input logic pend);
    int n;
    n = 0;
    while (O_VECTOR !== exp && n < 8) begin
      @(posedge I_MCLK);
      n++;
    end
    chk("vector", O_VECTOR, exp);
    if (O_VECTOR !== exp) give_verdict();
    chk("pending", {15'h0, O_PENDING}, {15'h0, pend});
  endtask
  // core takes the vector through the model
  task automatic fetch(input logic [15:0] exp);
    take <= 1'b1;
    @(posedge I_MCLK);
    take <= 1'b0;
    @(posedge I_MCLK);
    chk("fetched vector", O_VECTOR, exp);
    @(posedge I_MCLK);
  endtask
  task automatic pin_low(input int hold);
    ext_set <= 1'b1;
    @(posedge I_MCLK);
    ext_set <= 1'b0;
    repeat (hold) @(posedge I_MCLK);
  endtask
  task automatic t_reset();
    rd(8'h01, 8'hFF, 8'hF2);
    rd(8'h02, 8'h50, 8'h50);
    rd(8'h00, 8'hC0, 8'h40);
    rd(8'h07, 8'hFF, 8'h00);
    see(16'hFFFE, 1'b1);
    fetch(16'hFFFE);
    see(16'hFFF8, 1'b0);
    $display("test reset done");
  endtask
  task automatic t_nonmask();
    logic [15:0] v;
    {I_CLKMON_FAIL, I_WDOG_FAIL, I_OPCODE_TRAP, I_SWI} <= 4'hF;
    I_NMI_REQ_N <= 1'b0;
    for (int k = 0; k < 4; k++) begin
      v = 16'hFFFC - 16'(2 * k);
      see(v, 1'b1);
      fetch(v);
      {I_CLKMON_FAIL, I_WDOG_FAIL, I_OPCODE_TRAP, I_SWI} <= 4'h7 >> k;
    end
    repeat (4) @(posedge I_MCLK);
    see(16'hFFF8, 1'b0);
    wr(8'h02, 8'h10);
    see(16'hFFF4, 1'b1);
    fetch(16'hFFF4);
    I_NMI_REQ_N <= 1'b1;
    @(posedge I_MCLK);
    chk("x mask", {15'h0, O_X_MASK}, 16'h1);
    $display("test non-maskable done");
  endtask
  task automatic t_promote();
    wr(8'h01, 8'hD8);
    rd(8'h01, 8'hFF, 8'hD8);
    wr(8'h05, 8'h04);
    I_PERIPH_FLAG <= 25'h2002;
    wr(8'h02, 8'h40);
    see(16'hFFD8, 1'b1);
    fetch(16'hFFD8);
    I_PERIPH_FLAG <= 25'h2;
    repeat (2) @(posedge I_MCLK);
    see(16'hFFF8, 1'b0);
    wr(8'h02, 8'h40);
    see(16'hFFF0, 1'b1);
    I_PERIPH_FLAG <= 25'h2002;
    wr(8'h05, 8'h00);
    repeat (3) @(posedge I_MCLK);
    see(16'hFFF0, 1'b1);
    wr(8'h01, 8'hF0);
    rd(8'h01, 8'hFF, 8'hD8);
    fetch(16'hFFF0);
    $display("test promotion done");
  endtask
  task automatic t_ext();
    wr(8'h05, 8'h04);
    wr(8'h01, 8'hF4);
    wr(8'h03, 8'h01);
    I_WAKE_G_FLAG <= 7'h01;
    pin_low(0);
    wr(8'h02, 8'h40);
    see(16'hFFF2, 1'b1);
    fetch(16'hFFF2);
    wr(8'h02, 8'h40);
    see(16'hFFF0, 1'b1);
    wr(8'h02, 8'h50);
    wr(8'h01, 8'hCE);
    wr(8'h02, 8'h40);
    see(16'hFFCE, 1'b1);
    fetch(16'hFFCE);
    I_PERIPH_FLAG <= 25'h0;
    I_WAKE_G_FLAG <= 7'h00;
    I_LOCK_FLAG <= 1'b1;
    wr(8'h05, 8'h01);
    wr(8'h01, 8'hC2);
    wr(8'h02, 8'h40);
    see(16'hFFC2, 1'b1);
    fetch(16'hFFC2);
    I_LOCK_FLAG <= 1'b0;
    wr(8'h02, 8'h40);
    pin_low(0);
    see(16'hFFF2, 1'b1);
    ext_drop <= 1'b1;
    @(posedge I_MCLK);
    ext_drop <= 1'b0;
    see(16'hFFF8, 1'b0);
    wr(8'h02, 8'h50);
    wr(8'h00, 8'hC0);
    pin_low(3);
    ext_drop <= 1'b1;
    @(posedge I_MCLK);
    ext_drop <= 1'b0;
    wr(8'h02, 8'h40);
    see(16'hFFF2, 1'b1);
    fetch(16'hFFF2);
    wr(8'h02, 8'h40);
    repeat (3) @(posedge I_MCLK);
    see(16'hFFF8, 1'b0);
    $display("test external pin done");
  endtask
  // port h wake gating, limp-home, modulus promotion, disconnected pin
  task automatic t_gates();
    wr(8'h02, 8'h50);
    wr(8'h01, 8'hCC);
    wr(8'h04, 8'h80);
    wr(8'h05, 8'h0A);
    rd(8'h04, 8'hFF, 8'h80);
    I_PERIPH_FLAG <= 25'h80000;
    I_WAKE_H_FLAG <= 8'h7F;
    I_LIMP_FLAG <= 1'b1;
    wr(8'h02, 8'h40);
    see(16'hFFCC, 1'b1);
    fetch(16'hFFCC);
    I_PERIPH_FLAG <= 25'h0;
    wr(8'h02, 8'h40);
    see(16'hFFC2, 1'b1);
    I_WAKE_H_FLAG <= 8'h80;
    see(16'hFFCE, 1'b1);
    fetch(16'hFFCE);
    I_WAKE_H_FLAG <= 8'h00;
    I_LIMP_FLAG <= 1'b0;
    wr(8'h01, 8'hF2);
    wr(8'h00, 8'h00);
    pin_low(0);
    wr(8'h02, 8'h40);
    repeat (3) @(posedge I_MCLK);
    see(16'hFFF8, 1'b0);
    rd(8'h06, 8'h07, 8'h04);
    ext_drop <= 1'b1;
    @(posedge I_MCLK);
    ext_drop <= 1'b0;
    $display("test local gates done");
  endtask
  // main sequence
  initial begin
    repeat (2) @(posedge I_MCLK);
    I_RST_N <= 1'b1;
    @(posedge I_MCLK);
    t_reset();
    t_nonmask();
    t_promote();
    t_ext();
    t_gates();
    give_verdict();
  end
endmodule
